// [src/bsw_host.sv]
// host controller driving an 8k x 8 battery-backed sram
// Operation
// R1: write mode needs strobe and both selects
// R2: write starts at last assertion
// R3: write ends at first deassertion
// R4: host holds address stable through write
// R5: host waits recovery before next cycle
// R6: data set up before, held after end
// R7: host keeps output gate high writing
// R8: device floats outputs after strobe falls
// R9: supply in trip window deselects device
// R10: deselected device ignores inputs, floats data
// R11: failure mid-write harms only that byte
// R12: battery powers array below switchover
// R13: power-up keeps array write protected
// R14: host keeps chip deselected during power-up
// R15: host waits recovery after supply returns
// R16: device asserts alert at detect trip
// R17: device deselects 10-40 us after alert
// R18: alert open-drain low, pull-up required
// R19: alert released within 120 us
// R20: supply state given as digital flags
`timescale 1ns/100ps
`default_nettype none
module bsw_host
    import bsw_pkg::*;
#(
    parameter int RECOVERY_CYCLES = RECOVERY_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // user side
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output var  logic              req_ready,
    output var  logic              rsp_valid,
    output var  logic [DATA_W-1:0] rsp_rdata,
    output var  logic              power_ok,
    output var  logic              alert_seen,
    // sram pins
    output var  logic [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] mem_dq_in,
    output var  logic [DATA_W-1:0] mem_dq_out,
    output var  logic              mem_dq_oe_n,
    output var  logic              select_low_active_n,
    output var  logic              select_high_active,
    output var  logic              mem_gate_n,
    output var  logic              mem_write_n,
    input  wire logic              alert_n
);
    localparam int CNT_W = $clog2(RECOVERY_CYCLES + 2);

    // refuse counts that the shared cycle counter cannot hold
    if (RECOVERY_CYCLES < RD_ACCESS_CYC + 1 || WR_PULSE_CYC < 1
        || ADDR_HOLD_CYC < 1) begin : g_bad_counts
        $error("bsw_host: cycle counts out of range");
    end

    typedef struct packed {
        bsw_state_t        st;
        logic [CNT_W-1:0]  cnt;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic              dq_oe_n;
        logic              sel_n;
        logic              sel_h;
        logic              gate_n;
        logic              we_n;
        logic              ready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic              pok;
        logic              alert;
    } bsw_host_t;

    bsw_host_t s_reg;
    bsw_host_t s_next;

    logic [DATA_W:0] pins_sync;

    // data and alert come from the far side, so they are synchronised;
    // alert enters inverted so the cleared flops match its idle level
    bsw_sync #(
        .WIDTH (DATA_W + 1)
    ) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d_in    ({!alert_n, mem_dq_in}),
        .q_out   (pins_sync)
    );

    logic alert_low;
    assign alert_low = pins_sync[DATA_W]; // [R18]

    // next-state logic
    always_comb begin
        s_next        = s_reg;
        s_next.rvalid = 1'b0;
        s_next.alert  = alert_low;
        // power good drops at once, even while a cycle still finishes
        if (alert_low) begin
            s_next.pok = 1'b0;
        end
        case (s_reg.st)
            BSW_ST_BOOT: begin
                // selects parked inactive while supply rises [R14]
                s_next.sel_n  = 1'b1;
                s_next.sel_h  = 1'b0;
                s_next.we_n   = 1'b1;
                s_next.ready  = 1'b0;
                if (alert_low) begin
                    s_next.cnt = '0;
                end else if (s_reg.cnt >= CNT_W'(RECOVERY_CYCLES)) begin
                    s_next.st    = BSW_ST_IDLE; // [R15]
                    s_next.pok   = 1'b1;
                    s_next.ready = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            BSW_ST_IDLE: begin
                if (alert_low) begin
                    // supply failing: stop issuing cycles [R9] [R16]
                    s_next.st    = BSW_ST_FAIL;
                    s_next.pok   = 1'b0;
                    s_next.ready = 1'b0;
                end else if (req_valid) begin
                    s_next.ready = 1'b0;
                    s_next.addr  = req_addr;
                    s_next.wr    = req_write;
                    s_next.dout  = req_wdata;
                    s_next.cnt   = '0;
                    s_next.sel_n = 1'b0;
                    s_next.sel_h = 1'b1; // [R1]
                    if (req_write) begin
                        // gate kept high, data driven with strobe [R7] [R6]
                        s_next.gate_n  = 1'b1;
                        s_next.we_n    = 1'b0; // [R2]
                        s_next.dq_oe_n = 1'b0;
                        s_next.st      = BSW_ST_WPULSE;
                    end else begin
                        s_next.gate_n = 1'b0;
                        s_next.st     = BSW_ST_RPULSE;
                    end
                end
            end
            BSW_ST_WPULSE: begin
                // pulse long enough for data setup too
                if (s_reg.cnt >= CNT_W'(WR_PULSE_CYC - 1)) begin
                    // strobe and select_low_active_n rise and select_high_active falls together to end the write [R3]
                    s_next.we_n  = 1'b1;
                    s_next.sel_n = 1'b1;
                    s_next.sel_h = 1'b0;
                    s_next.cnt   = '0;
                    s_next.st    = BSW_ST_HOLD;
                end else begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            BSW_ST_RPULSE: begin
                // extra cycles cover the input synchroniser
                if (s_reg.cnt >= CNT_W'(RD_ACCESS_CYC + 1)) begin
                    s_next.rdata  = pins_sync[DATA_W-1:0];
                    s_next.rvalid = 1'b1;
                    s_next.gate_n = 1'b1;
                    s_next.sel_n  = 1'b1;
                    s_next.sel_h  = 1'b0;
                    s_next.cnt    = '0;
                    s_next.st     = BSW_ST_HOLD;
                end else begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            BSW_ST_HOLD: begin
                // address and data held past the end, then recovery [R4] [R5]
                if (s_reg.cnt >= CNT_W'(ADDR_HOLD_CYC - 1)) begin
                    s_next.dq_oe_n = 1'b1;
                    s_next.cnt     = '0;
                    if (alert_low || !s_reg.pok) begin
                        // alert hit mid-cycle: park, then full recovery [R9]
                        s_next.st    = BSW_ST_FAIL;
                        s_next.ready = 1'b0;
                    end else begin
                        s_next.st    = BSW_ST_IDLE;
                        s_next.ready = 1'b1;
                    end
                end else begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            BSW_ST_FAIL: begin
                // device ignores pins once it deselects; wait for alert release [R10]
                s_next.sel_n   = 1'b1;
                s_next.sel_h   = 1'b0;
                s_next.we_n    = 1'b1;
                s_next.gate_n  = 1'b1;
                s_next.dq_oe_n = 1'b1;
                if (!alert_low) begin
                    s_next.cnt = '0;
                    s_next.st  = BSW_ST_BOOT; // [R15]
                end
            end
            default: begin
                s_next = s_reg;
                s_next.st = BSW_ST_BOOT;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg         <= '0;
            s_reg.st      <= BSW_ST_BOOT;
            s_reg.dq_oe_n <= 1'b1;
            s_reg.sel_n   <= 1'b1;
            s_reg.gate_n  <= 1'b1;
            s_reg.we_n    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output straight from the state register
    assign req_ready           = s_reg.ready;
    assign rsp_valid           = s_reg.rvalid;
    assign rsp_rdata           = s_reg.rdata;
    assign power_ok            = s_reg.pok;
    assign alert_seen          = s_reg.alert;
    assign mem_addr            = s_reg.addr;
    assign mem_dq_out          = s_reg.dout;
    assign mem_dq_oe_n         = s_reg.dq_oe_n;
    assign select_low_active_n = s_reg.sel_n;
    assign select_high_active  = s_reg.sel_h;
    assign mem_gate_n          = s_reg.gate_n;
    assign mem_write_n         = s_reg.we_n;
endmodule : bsw_host
`default_nettype wire

// [shared/bsw_pkg.sv]
// constants and types shared by the battery sram host controller
package bsw_pkg;
    // bus geometry
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    // clock rate in kHz, 25 MHz reference
    localparam int CLK_KHZ = 25_000;
    // write pulse width, least, ns
    localparam int WR_PULSE_NS = 80;
    // data setup before terminating edge, least, ns
    localparam int DATA_SETUP_NS = 50;
    // address and data hold / recovery after strobe rise, least, ns
    localparam int ADDR_HOLD_NS = 10;
    // read cycle: address to data valid, most, ns
    localparam int RD_ACCESS_NS = 100;
    // power-up recovery before accesses, least, us
    localparam int RECOVERY_US = 1000;
    // least times round up to whole cycles
    localparam int WR_PULSE_CYC = (WR_PULSE_NS * CLK_KHZ + 999_999) / 1_000_000;
    localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS * CLK_KHZ + 999_999) / 1_000_000;
    localparam int RD_ACCESS_CYC = (RD_ACCESS_NS * CLK_KHZ + 999_999) / 1_000_000 + 1;
    localparam int RECOVERY_CYC = RECOVERY_US * (CLK_KHZ / 1000);
    // state encodings, one-hot
    typedef enum logic [5:0] {
        BSW_ST_BOOT   = 6'b00_0001,
        BSW_ST_IDLE   = 6'b00_0010,
        BSW_ST_WPULSE = 6'b00_0100,
        BSW_ST_RPULSE = 6'b00_1000,
        BSW_ST_HOLD   = 6'b01_0000,
        BSW_ST_FAIL   = 6'b10_0000
    } bsw_state_t;
endpackage : bsw_pkg

// [src/bsw_sync.sv]
// two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
`default_nettype none
module bsw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d_in,
    output var  logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage read only by the second stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule : bsw_sync
`default_nettype wire

// [tb/bsw_host_checker.sv]
// pin timing assertions for the battery sram host controller
`timescale 1ns/100ps
`default_nettype none
module bsw_host_checker
    import bsw_pkg::*;
#(
    parameter int RECOVERY_CYCLES = RECOVERY_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              req_ready,
    input  wire logic              power_ok,
    input  wire logic              alert_seen,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] mem_dq_out,
    input  wire logic              mem_dq_oe_n,
    input  wire logic              select_low_active_n,
    input  wire logic              select_high_active,
    input  wire logic              mem_gate_n,
    input  wire logic              mem_write_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [15:0] calm_cnt;
    // quiet cycles since alert went away, saturating so it never wraps
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            calm_cnt <= 16'h0000;
        else if (alert_seen)
            calm_cnt <= 16'h0000;
        else if (calm_cnt != 16'hFFFF)
            calm_cnt <= calm_cnt + 16'h0001;
    end
    property p_sel; !mem_write_n |-> !select_low_active_n && select_high_active;
    endproperty
    a_sel: assert property (p_sel) else $error("strobe unselected");
    property p_pulse; $fell(mem_write_n) |=> !mem_write_n ##1 mem_write_n;
    endproperty
    a_pulse: assert property (p_pulse) else $error("bad pulse");
    property p_hold; !mem_write_n |=> $stable(mem_addr) && $stable(mem_dq_out);
    endproperty
    a_hold: assert property (p_hold) else $error("addr or data moved");
    property p_drive; !mem_write_n |-> !mem_dq_oe_n; endproperty
    a_drive: assert property (p_drive) else $error("data not driven");
    property p_gate; !mem_write_n |-> mem_gate_n; endproperty
    a_gate: assert property (p_gate) else $error("gate on in write");
    property p_rec; $rose(mem_write_n) |-> select_low_active_n
        ##1 (mem_write_n && select_low_active_n); endproperty
    a_rec: assert property (p_rec) else $error("no recovery gap");
    property p_rdy; req_ready |-> power_ok; endproperty
    a_rdy: assert property (p_rdy) else $error("ready without power");
    property p_alert; alert_seen[*2] |-> !power_ok; endproperty
    a_alert: assert property (p_alert) else $error("power ok in alert");
    property p_park; alert_seen[*8] |-> select_low_active_n
        && !select_high_active && mem_write_n && mem_gate_n; endproperty
    a_park: assert property (p_park) else $error("selected in alert");
    property p_boot; $rose(power_ok) |-> calm_cnt >= RECOVERY_CYCLES;
    endproperty
    a_boot: assert property (p_boot) else $error("recovery too short");
endmodule : bsw_host_checker
bind bsw_host bsw_host_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_chk (
    .ref_clk, .nrst, .req_ready, .power_ok, .alert_seen, .mem_addr,
    .mem_dq_out, .mem_dq_oe_n, .select_low_active_n, .select_high_active,
    .mem_gate_n, .mem_write_n);
`default_nettype wire

// [tb/bsw_sram_model.sv]
// behavioural battery-backed sram as seen from its host
`timescale 1ns/100ps
`default_nettype none
module bsw_sram_model
    import bsw_pkg::*;
#(
    parameter int DESEL_NS   = 20_000,
    parameter int RELEASE_NS = 100_000
) (
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] din,
    input  wire logic              sel_n,
    input  wire logic              sel_h,
    input  wire logic              gate_n,
    input  wire logic              wr_n,
    input  wire logic              supply_low, // digital trip flag
    output var  logic [DATA_W-1:0] dout,
    output var  logic              alert_pull
);
    logic [DATA_W-1:0] mem [2**ADDR_W]; // kept on battery too
    logic              off   = 1'b0;
    logic              alert = 1'b0;
    wire               sel   = !sel_n && sel_h && !off;
    wire               wr    = sel && !wr_n;
    // byte lands at the earliest deassertion; a cut write hits one byte
    always @(negedge wr) mem[addr] <= din;
    // floats once strobe falls; a floating bus shows the inverse
    assign dout = (sel && !gate_n && wr_n) ? mem[addr] : ~mem[addr];
    // alert at once, deselect later, release after supply returns
    always @(supply_low) begin
        if (supply_low) begin
            alert = 1'b1;
            off <= #(DESEL_NS) 1'b1;
        end else begin
            alert <= #(RELEASE_NS) 1'b0;
            off <= #(RELEASE_NS) 1'b0;
        end
    end
    assign alert_pull = alert; // open drain, only ever pulls low
endmodule : bsw_sram_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the battery sram host controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import bsw_pkg::*;
    localparam int REC = 20;
    localparam int REL_CYC = 2500;
    logic              ref_clk    = 1'b0;
    logic              nrst       = 1'b0;
    logic              req_valid  = 1'b0;
    logic              req_write  = 1'b0;
    logic              supply_low = 1'b0;
    logic [ADDR_W-1:0] req_addr   = '0;
    logic [DATA_W-1:0] req_wdata  = '0;
    logic              req_ready, rsp_valid, power_ok, alert_seen, alert_pull;
    logic              select_low_active_n, select_high_active;
    logic              mem_gate_n, mem_write_n, mem_dq_oe_n;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] rsp_rdata, mem_dq_out, dout;
    logic [ADDR_W-1:0] adr [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
    logic [DATA_W-1:0] dat [3] = '{8'h5A, 8'hA5, 8'h3C};
    int                num_errors  = 0;
    int                checks_done = 0;
    always #20 ref_clk = ~ref_clk;
    // pull-up on the alert line; pin is shared, host only drives in writes
    bsw_host #(.RECOVERY_CYCLES(REC)) DUT (
        .ref_clk, .nrst, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_ready, .rsp_valid, .rsp_rdata, .power_ok, .alert_seen,
        .mem_addr, .mem_dq_in(mem_dq_oe_n ? dout : mem_dq_out),
        .mem_dq_out, .mem_dq_oe_n, .select_low_active_n,
        .select_high_active, .mem_gate_n, .mem_write_n,
        .alert_n(!alert_pull));
    bsw_sram_model u_mem (
        .addr(mem_addr), .din(mem_dq_out), .sel_n(select_low_active_n),
        .sel_h(select_high_active), .gate_n(mem_gate_n),
        .wr_n(mem_write_n), .supply_low, .dout, .alert_pull);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic wait_ready(output int n);
        for (n = 0; req_ready !== 1'b1 && n < 5000; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 5000) chk(16'h0000, 16'h0001);
    endtask : wait_ready
    // one request; pf drops the supply just after the taking edge
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic pf,
                        output logic [DATA_W-1:0] q);
        int n;
        wait_ready(n);
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = a;
        req_wdata = d;
        @(posedge ref_clk);
        #1 req_valid = 1'b0;
        if (pf) supply_low = 1'b1;
        for (n = 0; n < 20 && !wr && rsp_valid !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        q = rsp_rdata;
    endtask : xfer
    task automatic t_boot();
        int n;
        wait_ready(n);
        chk(16'(n >= REC), 16'h0001);
        chk(16'(power_ok), 16'h0001);
    endtask : t_boot
    // corner and pattern addresses written back to back, then read back
    task automatic t_rw();
        logic [DATA_W-1:0] q;
        foreach (adr[i]) xfer(1'b1, adr[i], dat[i], 1'b0, q);
        foreach (adr[i]) begin
            xfer(1'b0, adr[i], 8'h00, 1'b0, q);
            chk(16'(q), 16'(dat[i]));
        end
    endtask : t_rw
    // supply fails mid-write, stays down past deselect, then returns
    task automatic t_fail();
        logic [DATA_W-1:0] q;
        int n;
        xfer(1'b1, 13'h0100, 8'h77, 1'b1, q);
        repeat (1000) @(posedge ref_clk);
        #1 chk(16'({alert_seen, power_ok, req_ready}), 16'h0004);
        supply_low = 1'b0;
        wait_ready(n);
        chk(16'(n > REL_CYC + REC), 16'h0001);
        xfer(1'b0, 13'h0100, 8'h00, 1'b0, q);
        chk(16'(q), 16'h0077);
        xfer(1'b0, adr[1], 8'h00, 1'b0, q);
        chk(16'(q), 16'(dat[1]));
    endtask : t_fail
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 nrst = 1'b1;
        t_boot();
        t_rw();
        t_fail();
        stop_test();
    end
    // watchdog, about three times the expected run
    initial begin
        #(40 * 12_000);
        chk(16'h0000, 16'h0001);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
